// *** core/sfwp_pkg.sv ***
// Shared constants and types of the serial flash write-protection block
package sfwp_pkg;

    // Command codes
    localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
    localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
    localparam logic [7:0] OP_BLOCK32_ERASE  = 8'h52;
    localparam logic [7:0] OP_BLOCK64_ERASE  = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A   = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B   = 8'hc7;
    localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
    localparam logic [7:0] OP_DEEP_SLEEP     = 8'hb9;
    localparam logic [7:0] OP_ENTER_SECURE   = 8'hb1;
    localparam logic [7:0] OP_EXIT_SECURE    = 8'hc1;
    localparam logic [7:0] OP_SECURITY_WRITE = 8'h2f;

    // Frame lengths in whole bytes; the byte counter saturates at LEN_SAT
    localparam logic [3:0] LEN_PLAIN      = 4'h1;
    localparam logic [3:0] LEN_ERASE      = 4'h4;
    localparam logic [3:0] LEN_PROGRAM    = 4'h5;
    localparam logic [3:0] LEN_STATUS_MIN = 4'h2;
    localparam logic [3:0] LEN_STATUS_MAX = 4'h3;
    localparam logic [3:0] LEN_SAT        = 4'hf;

    // Address layout: 128 blocks of 64 KB, OTP rows split at bit 9
    localparam int         ADDR_W      = 24;
    localparam int         BLOCK_LSB   = 16;
    localparam int         BLOCK_W     = 7;
    localparam logic [7:0] NUM_BLOCKS  = 8'h80;
    localparam int         OTP_ROW_BIT = 9;
    localparam logic [23:0] OTP_MASK   = 24'h0003ff;

    // Reset values
    localparam logic [3:0] BP_RESET   = 4'h0;
    localparam logic [2:0] PIN_IDLE   = 3'h7;

    // Status byte, MSB first: guard, quad enable, protect level, latch, busy
    typedef struct packed {
        logic       status_write_guard;
        logic       quad_enable;
        logic [3:0] block_protect_level;
        logic       write_enable_latch;
        logic       write_in_progress;
    } sfwp_status_t;

    typedef enum logic [2:0] {
        SFWP_OP_SECTOR,
        SFWP_OP_BLOCK32,
        SFWP_OP_BLOCK64,
        SFWP_OP_CHIP,
        SFWP_OP_PROGRAM
    } sfwp_op_kind_t;

    typedef struct packed {
        logic          valid;
        sfwp_op_kind_t kind;
        logic          secure;
        logic [23:0]   addr;
    } sfwp_op_req_t;

    typedef enum logic [1:0] {
        SFWP_READY,
        SFWP_BUSY,
        SFWP_SLEEP
    } sfwp_mode_t;

endpackage : sfwp_pkg

// *** core/sfwp_top.sv ***
// Command front end and write protection of a serial multi-I/O NOR flash
//
// What this block does
// - Power-up reset leaves the command logic idle; no partial command runs.
// - Contents change only after a complete, valid, accepted data-changing command.
// - Count received bits; accept only whole bytes ending on a byte boundary.
// - Write, erase, program, control commands ending off a byte boundary are rejected.
// - Data-changing commands need the write-enable latch set by write_enable_cmd.
// - In deep sleep every command is ignored; a chip-select toggle wakes it.
// - Four protect-level bits mark a read-only region; program/erase there refused.
// - Top selection: levels 1-7 protect highest 1..64 blocks; 8-15 protect all.
// - Bottom selection: levels 1-7 protect lowest 1..64 blocks; 8-15 protect all.
// - Chip erase runs only when all four protect-level bits are zero.
// - Write-guard pin shields protect bits and status guard bit in hardware mode.
// - In quad mode hardware protection is off; guard pin is data line 2.
// - Data-in pin is input only in single I/O; bidirectional in quad read.
// - Active-low write-guard pin protects outside quad; data line 2 in quad.
// - Fourth pin is hardware reset or data line 3, by part option.
// - Pause option: fourth pin suspends serial transfer, or data line 3 in quad.
// - Secured area is 8K bits: customer row and factory row of 4K bits.
// - Customer row at 000h-1FFh, factory row 200h-3FFh; upper address ignored.
// - Security bit 0 reports the factory lock of the second row.
// - security_reg_write_cmd locks the customer row; security bit 1 becomes one.
// - Secured programming: enter command, normal program, then exit command.
// - A locked secured row never changes again.
// - While in secured-area mode the main array cannot be reached.
// - A write-in-progress bit shows when program or erase has finished.
module sfwp_top
    import sfwp_pkg::*;
#(
    parameter bit PAUSE_OPTION = 1'b0
) (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    input  wire logic                  i_link_sclk,
    input  wire logic                  i_cs_n,
    input  wire logic                  i_serial_in_line0,
    input  wire logic                  i_write_guard_line2_n,
    input  wire logic                  i_hard_reset_line3_n,
    input  wire logic                  i_factory_lock,
    input  wire logic                  i_top_bottom_select,
    input  wire logic                  i_op_done,
    output sfwp_pkg::sfwp_status_t     o_status,
    output sfwp_pkg::sfwp_op_req_t     o_op_req,
    output logic                       o_factory_lock,
    output logic                       o_customer_lock,
    output logic                       o_secure_area,
    output logic                       o_deep_sleep,
    output logic                       o_cmd_reject
);
    import sfwp_pkg::*;

    if (PAUSE_OPTION !== 1'b0 && PAUSE_OPTION !== 1'b1) begin : g_chk
        $error("PAUSE_OPTION must be 0 or 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the serial clock

    logic       fresh_r;
    logic       frame_tog_r;
    logic [2:0] bits_r;
    logic [3:0] bytes_r;
    logic [7:0] shift_r;
    logic [7:0] opcode_r;
    logic [7:0] data_r;
    logic [23:0] addr_r;
    logic       qe_s1_r;
    logic       qe_s2_r;
    logic       qe_r;
    logic       frame_rstn;
    logic       pause_act;
    logic       first_bit;
    logic [2:0] bits_nxt;
    logic [3:0] byte_idx;
    logic [7:0] shift_nxt;

    // Deselect clears only the frame marker; counts and bytes survive the
    // stopped serial clock so the system side can read them afterwards
    assign frame_rstn = i_rstn & ~i_cs_n;
    assign first_bit  = ~fresh_r;
    assign bits_nxt   = first_bit ? 3'h1 : bits_r + 3'h1;
    assign byte_idx   = first_bit ? 4'h0 : bytes_r;
    assign shift_nxt  = {(first_bit ? 7'h00 : shift_r[6:0]), i_serial_in_line0};

    // Pause only on that part option and never in quad mode
    assign pause_act = PAUSE_OPTION & ~qe_s2_r & ~i_hard_reset_line3_n;

    always_ff @(posedge i_link_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            qe_s1_r <= 1'b0;
            qe_s2_r <= 1'b0;
        end else begin
            qe_s1_r <= qe_r;
            qe_s2_r <= qe_s1_r;
        end
    end

    always_ff @(posedge i_link_sclk or negedge frame_rstn) begin
        if (!frame_rstn) begin
            fresh_r <= 1'b0;
        end else if (!pause_act) begin
            fresh_r <= 1'b1;
        end
    end

    always_ff @(posedge i_link_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            frame_tog_r <= 1'b0;
            bits_r      <= 3'h0;
            bytes_r     <= 4'h0;
            shift_r     <= 8'h00;
        end else if (!pause_act) begin
            if (first_bit) begin
                frame_tog_r <= ~frame_tog_r;
            end
            bits_r  <= bits_nxt;
            shift_r <= shift_nxt;
            if (bits_nxt == 3'h0 && byte_idx != LEN_SAT) begin
                bytes_r <= byte_idx + 4'h1;
            end else if (first_bit) begin
                bytes_r <= 4'h0;
            end
        end
    end

    always_ff @(posedge i_link_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            opcode_r <= 8'h00;
            addr_r   <= 24'h000000;
            data_r   <= 8'h00;
        end else if (!pause_act && bits_nxt == 3'h0) begin
            case (byte_idx)
                4'h0: begin
                    opcode_r <= shift_nxt;
                end
                4'h1: begin
                    addr_r[23:16] <= shift_nxt;
                    data_r        <= shift_nxt;
                end
                4'h2: begin
                    addr_r[15:8] <= shift_nxt;
                end
                4'h3: begin
                    addr_r[7:0] <= shift_nxt;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: chip select, write guard, fourth pin

    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s3_r;
    logic [2:0] pin_lvl_r;
    logic       tog_s1_r;
    logic       tog_s2_r;
    logic       tog_seen_r;
    logic       cs_rise;
    logic       frame_bits;

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_s1_r  <= PIN_IDLE;
            pin_s2_r  <= PIN_IDLE;
            pin_s3_r  <= PIN_IDLE;
            pin_lvl_r <= PIN_IDLE;
        end else begin
            pin_s1_r <= {i_hard_reset_line3_n, i_write_guard_line2_n, i_cs_n};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            for (int i = 0; i < 3; i++) begin
                if (pin_s2_r[i] == pin_s3_r[i]) begin
                    pin_lvl_r[i] <= pin_s3_r[i];
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            tog_s1_r   <= 1'b0;
            tog_s2_r   <= 1'b0;
            tog_seen_r <= 1'b0;
        end else begin
            tog_s1_r <= frame_tog_r;
            tog_s2_r <= tog_s1_r;
            if (cs_rise) begin
                tog_seen_r <= tog_s2_r;
            end
        end
    end

    // Deselect seen settled; the link registers are quiet by now
    assign cs_rise    = pin_s2_r[0] & pin_s3_r[0] & ~pin_lvl_r[0];
    // A frame without any serial clock edge carries no command
    assign frame_bits = tog_s2_r ^ tog_seen_r;

    ////////////////////////////////////////////////////////////////////////
    // Command decode and protection checks

    sfwp_mode_t    mode_r;
    logic          wel_r;
    logic [3:0]    bp_r;
    logic          status_write_guard_r;
    logic          qe_sys_r;
    logic          secure_r;
    logic          cust_lock_r;
    logic          fact_lock_r;
    logic          strap_done_r;
    logic          hw_reset;
    logic          guard_low;
    logic          blk_locked;
    logic          row_locked;
    logic          changes;
    logic          allowed;
    logic          is_array_op;
    logic          len_ok;
    logic          cmd_ok;
    logic          take;
    logic          exec;
    logic [3:0]    len_min;
    logic [3:0]    len_max;
    sfwp_op_kind_t kind;

    assign qe_r = qe_sys_r;

    // Fourth pin is a reset only on the reset option and outside quad mode
    assign hw_reset  = ~PAUSE_OPTION & ~qe_sys_r & ~pin_lvl_r[2];
    assign guard_low = ~qe_sys_r & ~pin_lvl_r[1];

    function automatic logic region_hit(input logic [3:0] bp, input logic tb,
                                        input logic [BLOCK_W-1:0] blk);
        logic [7:0] n;
        n = 8'h00;
        if (bp == 4'h0) begin
            region_hit = 1'b0;
        end else if (bp[3]) begin
            region_hit = 1'b1;
        end else begin
            n = 8'h01 << (bp[2:0] - 3'h1);
            if (tb) begin
                region_hit = {1'b0, blk} < n;
            end else begin
                region_hit = {1'b0, blk} >= NUM_BLOCKS - n;
            end
        end
    endfunction : region_hit

    assign blk_locked = region_hit(bp_r, i_top_bottom_select,
                                   addr_r[BLOCK_LSB +: BLOCK_W]);
    // Row 1 is the factory row, row 0 the customer row
    assign row_locked = addr_r[OTP_ROW_BIT] ? fact_lock_r : cust_lock_r;

    always_comb begin
        len_min     = LEN_PLAIN;
        len_max     = LEN_PLAIN;
        changes     = 1'b0;
        allowed     = 1'b1;
        is_array_op = 1'b0;
        kind        = SFWP_OP_SECTOR;
        case (opcode_r)
            OP_WRITE_ENABLE, OP_WRITE_DISABLE, OP_ENTER_SECURE, OP_EXIT_SECURE,
            OP_DEEP_SLEEP: begin
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
                changes     = 1'b1;
                is_array_op = 1'b1;
                kind        = SFWP_OP_CHIP;
                allowed     = (bp_r == 4'h0) & ~secure_r;
            end
            OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE: begin
                len_min     = LEN_ERASE;
                len_max     = LEN_ERASE;
                changes     = 1'b1;
                is_array_op = 1'b1;
                kind        = (opcode_r == OP_SECTOR_ERASE) ? SFWP_OP_SECTOR :
                              (opcode_r == OP_BLOCK32_ERASE) ? SFWP_OP_BLOCK32 :
                              SFWP_OP_BLOCK64;
                allowed     = ~secure_r & ~blk_locked;
            end
            OP_PAGE_PROGRAM: begin
                len_min     = LEN_PROGRAM;
                len_max     = LEN_SAT;
                changes     = 1'b1;
                is_array_op = 1'b1;
                kind        = SFWP_OP_PROGRAM;
                allowed     = secure_r ? ~row_locked : ~blk_locked;
            end
            OP_STATUS_WRITE: begin
                len_min = LEN_STATUS_MIN;
                len_max = LEN_STATUS_MAX;
                changes = 1'b1;
                allowed = ~(guard_low & status_write_guard_r);
            end
            OP_SECURITY_WRITE: begin
                changes = 1'b1;
            end
            default: begin
                // Unknown codes never match a length
                len_min = LEN_SAT;
                len_max = 4'h0;
            end
        endcase
        len_ok = (bits_r == 3'h0) & (bytes_r >= len_min) & (bytes_r <= len_max);
        cmd_ok = len_ok & (~changes | wel_r) & allowed;
    end

    // Busy, asleep or held in reset: frames are dropped without effect
    assign take = cs_rise & frame_bits & (mode_r == SFWP_READY) & ~hw_reset;
    assign exec = take & cmd_ok;

    ////////////////////////////////////////////////////////////////////////
    // Device state

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            mode_r <= SFWP_READY;
        end else begin
            case (mode_r)
                SFWP_READY: begin
                    if (exec && opcode_r == OP_DEEP_SLEEP) begin
                        mode_r <= SFWP_SLEEP;
                    end else if (exec && is_array_op) begin
                        mode_r <= SFWP_BUSY;
                    end
                end
                SFWP_BUSY: begin
                    if (i_op_done) begin
                        mode_r <= SFWP_READY;
                    end
                end
                SFWP_SLEEP: begin
                    if (cs_rise || hw_reset) begin
                        mode_r <= SFWP_READY;
                    end
                end
                default: begin
                    mode_r <= SFWP_READY;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            wel_r <= 1'b0;
        end else if (hw_reset) begin
            wel_r <= 1'b0;
        end else if (exec && opcode_r == OP_WRITE_ENABLE) begin
            wel_r <= 1'b1;
        end else if (exec && (changes || opcode_r == OP_WRITE_DISABLE)) begin
            wel_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            bp_r     <= BP_RESET;
            status_write_guard_r   <= 1'b0;
            qe_sys_r <= 1'b0;
        end else if (exec && opcode_r == OP_STATUS_WRITE) begin
            status_write_guard_r   <= data_r[7];
            qe_sys_r <= data_r[6];
            bp_r     <= data_r[5:2];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            secure_r <= 1'b0;
        end else if (hw_reset) begin
            secure_r <= 1'b0;
        end else if (exec && opcode_r == OP_ENTER_SECURE) begin
            secure_r <= 1'b1;
        end else if (exec && opcode_r == OP_EXIT_SECURE) begin
            secure_r <= 1'b0;
        end
    end

    // Lock bits only ever set; nothing here clears them after reset
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            cust_lock_r  <= 1'b0;
            fact_lock_r  <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            if (!strap_done_r) begin
                fact_lock_r  <= i_factory_lock;
                strap_done_r <= 1'b1;
            end
            if (exec && opcode_r == OP_SECURITY_WRITE) begin
                cust_lock_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_op_req     <= '0;
            o_cmd_reject <= 1'b0;
        end else begin
            o_op_req.valid  <= exec & is_array_op;
            o_op_req.kind   <= kind;
            o_op_req.secure <= secure_r;
            // Secured area keeps only the low address bits
            o_op_req.addr   <= secure_r ? (addr_r & OTP_MASK) : addr_r;
            o_cmd_reject    <= take & ~cmd_ok;
        end
    end

    assign o_status.status_write_guard  = status_write_guard_r;
    assign o_status.quad_enable         = qe_sys_r;
    assign o_status.block_protect_level = bp_r;
    assign o_status.write_enable_latch  = wel_r;
    assign o_status.write_in_progress   = (mode_r == SFWP_BUSY);
    assign o_factory_lock  = fact_lock_r;
    assign o_customer_lock = cust_lock_r;
    assign o_secure_area   = secure_r;
    assign o_deep_sleep    = (mode_r == SFWP_SLEEP);

endmodule : sfwp_top

// *** test/sfwp_host_model.sv ***
// Serial bus master model: chip select, link clock and data line
module sfwp_host_model (
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_data = 1'b0;
    end

    // Mode 0 master at a 160 ns link period; the clock stands low between frames.
    // Slow only delays the start, so the link phase wanders against the system clock
    task automatic send(input logic [39:0] bits, input int n, input int slow);
        #(23 + slow);
        o_cs_n = 1'b0;
        for (int k = 0; k < n; k++) begin
            o_data = bits[39-k];
            #(80);
            o_sclk = 1'b1;
            #(80);
            o_sclk = 1'b0;
        end
        #(60);
        o_cs_n = 1'b1;
        #(5);
        // Released line shows no stale value
        o_data = ~o_data;
    endtask : send
endmodule : sfwp_host_model

// *** test/sfwp_top_assertions.sv ***
// Concurrent checks on the outputs of the write-protection block
module sfwp_checker
    import sfwp_pkg::*;
(
    input wire logic                   i_clk_sys,
    input wire logic                   i_rstn,
    input wire logic                   i_top_bottom_select,
    input wire logic                   i_op_done,
    input wire sfwp_pkg::sfwp_status_t o_status,
    input wire sfwp_pkg::sfwp_op_req_t o_op_req,
    input wire logic                   o_factory_lock,
    input wire logic                   o_customer_lock,
    input wire logic                   o_deep_sleep,
    input wire logic                   o_cmd_reject
);
    timeunit 1ns;
    timeprecision 1ps;
    import sfwp_pkg::*;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    function automatic logic prot(input logic [6:0] blk, input logic [3:0] bp, input logic tb);
        int n;
        n = (bp == 4'h0) ? 0 : ((bp >= 4'h8) ? 128 : (1 << (bp - 1)));
        return tb ? (blk < n) : (blk >= 128 - n);
    endfunction : prot

    sequence s_issue;
        o_op_req.valid;
    endsequence
    sequence s_finish;
        o_status.write_in_progress && i_op_done;
    endsequence

    a_issue_excl: assert property (!(o_op_req.valid && o_cmd_reject))
        else $error("request and reject together");
    a_issue_busy: assert property (s_issue |-> o_status.write_in_progress)
        else $error("request without busy");
    a_issue_wel: assert property (s_issue |-> !o_status.write_enable_latch && $past(o_status.write_enable_latch))
        else $error("request without latch");
    a_issue_pulse: assert property (s_issue |=> !o_op_req.valid)
        else $error("request longer than a cycle");
    a_done_idle: assert property (s_finish |=> !o_status.write_in_progress)
        else $error("busy after done");
    a_busy_holds: assert property (o_status.write_in_progress && !i_op_done |=> $stable(o_status.write_in_progress))
        else $error("busy dropped early");
    a_chip_bp: assert property (s_issue and o_op_req.kind == SFWP_OP_CHIP |-> o_status.block_protect_level == 4'h0)
        else $error("chip erase while protected");
    a_secure_prog: assert property (s_issue and o_op_req.secure |-> o_op_req.kind == SFWP_OP_PROGRAM && o_op_req.addr[23:10] == 14'h0)
        else $error("bad secure request");
    a_locked_row: assert property (s_issue and o_op_req.secure |-> !(o_op_req.addr[9] ? o_factory_lock : o_customer_lock))
        else $error("program into locked row");
    a_block_prot: assert property (s_issue and !o_op_req.secure and o_op_req.kind != SFWP_OP_CHIP |-> !prot(o_op_req.addr[22:16], o_status.block_protect_level, i_top_bottom_select))
        else $error("protected block reached");
    a_sleep_quiet: assert property (o_deep_sleep |=> !o_op_req.valid && !o_cmd_reject)
        else $error("activity in deep sleep");
    a_lock_sticky: assert property (o_customer_lock |=> o_customer_lock)
        else $error("customer lock dropped");
endmodule : sfwp_checker

bind sfwp_top sfwp_checker u_chk (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_top_bottom_select(i_top_bottom_select),
    .i_op_done(i_op_done), .o_status(o_status), .o_op_req(o_op_req),
    .o_factory_lock(o_factory_lock), .o_customer_lock(o_customer_lock),
    .o_deep_sleep(o_deep_sleep), .o_cmd_reject(o_cmd_reject)
);

// *** test/serial_flash_write_protection_bench.sv ***
// Self-checking bench for the write-protection block
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module serial_flash_write_protection_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sfwp_pkg::*;

    logic clk, rstn, cs_n, sclk, sdi, guard_n, hrst_n, strap, tb, done_p, flk, clk_, sec, slp, rej;
    sfwp_status_t st;
    sfwp_op_req_t req, last_req;
    logic seen_req, seen_rej, p;
    int fail_count, cmp_count;
    logic [3:0] bp;
    logic [6:0] blk;
    logic [7:0] ops [3] = '{OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE};
    sfwp_op_kind_t kinds [3] = '{SFWP_OP_SECTOR, SFWP_OP_BLOCK32, SFWP_OP_BLOCK64};

    sfwp_host_model host (.o_cs_n(cs_n), .o_sclk(sclk), .o_data(sdi));
    sfwp_top #(.PAUSE_OPTION(1'b0)) dut (
        .i_clk_sys(clk), .i_rstn(rstn), .i_link_sclk(sclk), .i_cs_n(cs_n),
        .i_serial_in_line0(sdi), .i_write_guard_line2_n(guard_n), .i_hard_reset_line3_n(hrst_n),
        .i_factory_lock(strap), .i_top_bottom_select(tb), .i_op_done(done_p),
        .o_status(st), .o_op_req(req), .o_factory_lock(flk), .o_customer_lock(clk_),
        .o_secure_area(sec), .o_deep_sleep(slp), .o_cmd_reject(rej)
    );

    always #50 clk = ~clk;
    // One-cycle pulses are caught here so a frame can be judged afterwards
    always @(posedge clk) begin
        if (req.valid === 1'b1) begin
            seen_req = 1'b1;
            last_req = req;
        end
        if (rej === 1'b1) seen_rej = 1'b1;
    end

    function automatic logic prot(input logic [6:0] b, input logic [3:0] l, input logic t);
        int n;
        n = (l == 4'h0) ? 0 : ((l >= 4'h8) ? 128 : (1 << (l - 1)));
        return t ? (b < n) : (b >= 128 - n);
    endfunction : prot

    task automatic frame(input logic [39:0] b, input int n);
        seen_req = 1'b0;
        seen_rej = 1'b0;
        host.send(b, n, $urandom_range(0, 99));
        repeat (10) @(negedge clk);
    endtask : frame
    task automatic write_enable_cmd;
        frame({OP_WRITE_ENABLE, 32'h0}, 8);
    endtask : write_enable_cmd
    task automatic status_wr(input logic g, input logic q, input logic [3:0] l);
        write_enable_cmd();
        frame({OP_STATUS_WRITE, g, q, l, 2'b00, 24'h0}, 16);
    endtask : status_wr
    task automatic expect_out(input logic r, input logic j);
        `CHK(seen_req, r)
        `CHK(seen_rej, j)
    endtask : expect_out
    task automatic finish_op;
        done_p = 1'b1;
        @(negedge clk) done_p = 1'b0;
        @(negedge clk);
        `CHK(st.write_in_progress, 1'b0)
    endtask : finish_op
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        #5_000_000;
        fail_count++;
        final_report();
    end

    initial begin
        clk = 0; rstn = 0; guard_n = 1; hrst_n = 1; tb = 0; done_p = 0;
        void'($urandom(32'h51f9));
        strap = 1'($urandom_range(0, 1));
        repeat (2) @(negedge clk);
        rstn = 1;
        repeat (2) @(negedge clk);
        `CHK(st, 8'h00)
        `CHK(flk, strap)
        frame({OP_SECTOR_ERASE, 32'h0}, 32); expect_out(0, 1);
        write_enable_cmd(); `CHK(st.write_enable_latch, 1'b1)
        frame({OP_SECTOR_ERASE, 32'h0}, 31); expect_out(0, 1);
        write_enable_cmd(); frame({OP_SECTOR_ERASE, 32'h0}, 33); expect_out(0, 1);
        for (int i = 0; i < 24; i++) begin
            bp = (i < 16) ? i[3:0] : 4'($urandom_range(0, 15));
            tb = 1'($urandom_range(0, 1));
            blk = (i % 3 == 0) ? (tb ? 7'h00 : 7'h7f) : ((i % 3 == 1) ? 7'h3f : 7'($urandom));
            p = prot(blk, bp, tb);
            status_wr(0, 0, bp); `CHK(st.block_protect_level, bp)
            write_enable_cmd(); frame({ops[i%3], 1'b0, blk, 24'h0}, 32); expect_out(!p, p);
            if (!p) begin
                `CHK(last_req.kind, kinds[i%3])
                `CHK(last_req.addr, {1'b0, blk, 16'h0})
                `CHK(st.write_in_progress, 1'b1)
                finish_op();
            end
        end
        status_wr(0, 0, 4'h1); write_enable_cmd(); frame({OP_CHIP_ERASE_A, 32'h0}, 8); expect_out(0, 1);
        status_wr(0, 0, 4'h0);
        for (int i = 0; i < 2; i++) begin
            write_enable_cmd(); frame({(i == 0) ? OP_CHIP_ERASE_A : OP_CHIP_ERASE_B, 32'h0}, 8); expect_out(1, 0);
            finish_op();
        end
        status_wr(1, 0, 4'h2); `CHK(st.status_write_guard, 1'b1)
        guard_n = 0;
        status_wr(0, 0, 4'h0); expect_out(0, 1);
        `CHK(st.block_protect_level, 4'h2)
        guard_n = 1; status_wr(1, 1, 4'h2); `CHK(st.quad_enable, 1'b1)
        guard_n = 0;
        status_wr(0, 1, 4'h0); expect_out(0, 0);
        `CHK(st.block_protect_level, 4'h0)
        guard_n = 1; status_wr(0, 0, 4'h0);
        // Latch is clear here, so a latch seen later can only come from a frame in sleep
        frame({OP_DEEP_SLEEP, 32'h0}, 8); `CHK(slp, 1'b1)
        frame({OP_WRITE_ENABLE, 32'h0}, 8); `CHK(st.write_enable_latch, 1'b0)
        `CHK(slp, 1'b0)
        frame({OP_ENTER_SECURE, 32'h0}, 8); `CHK(sec, 1'b1)
        write_enable_cmd(); frame({OP_SECTOR_ERASE, 32'h0}, 32); expect_out(0, 1);
        write_enable_cmd(); frame({OP_PAGE_PROGRAM, 24'h123456, 8'ha5}, 40); expect_out(1, 0);
        `CHK(last_req.addr, 24'h000056)
        `CHK(last_req.secure, 1'b1)
        finish_op();
        write_enable_cmd(); frame({OP_SECURITY_WRITE, 32'h0}, 8); `CHK(clk_, 1'b1)
        write_enable_cmd(); frame({OP_PAGE_PROGRAM, 24'habc010, 8'h5a}, 40); expect_out(0, 1);
        write_enable_cmd(); frame({OP_PAGE_PROGRAM, 24'h000210, 8'h5a}, 40); expect_out(!strap, strap);
        if (seen_req) finish_op();
        frame({OP_EXIT_SECURE, 32'h0}, 8); `CHK(sec, 1'b0)
        write_enable_cmd(); hrst_n = 0;
        repeat (5) @(negedge clk);
        hrst_n = 1;
        repeat (5) @(negedge clk);
        `CHK(st.write_enable_latch, 1'b0)
        final_report();
    end
endmodule : serial_flash_write_protection_bench
